/* hw/scaler_prescale_output_window.sv */
// Horizontal prescaler with prefilters and the output window length logic.
module scaler_prescale_output_window #(
   parameter int DW = 8,
   parameter int LW = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port, one subaddress per byte
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   // Parameter set in use, 0 for A and 1 for B
   input wire logic set_sel_i,
   // Input sample stream, Y with multiplexed Cb and Cr
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [DW-1:0] in_y_i,
   input wire logic [DW-1:0] in_c_i,
   input wire logic in_eol_i,
   input wire logic in_sof_i,
   // Output stream to the fine scaler
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [DW-1:0] out_y_o,
   output logic [DW-1:0] out_c_o,
   output logic out_eol_o
);
   localparam int AW = 16;
   localparam int EW = 2 * DW + 1;
   localparam int REG_CNT_P = scaler_pkg::REG_CNT;

   typedef struct packed {
      logic [1:0][REG_CNT_P-1:0][7:0] regs;
      logic [7:0] rdata;
      logic [5:0][DW-1:0] hy;
      logic [7:0][DW-1:0] hc;
      logic [5:0] phase;
      logic cpar;
      logic [AW-1:0] acc_y;
      logic [1:0][AW-1:0] acc_c;
      logic [LW:0] hcnt;
      logic [LW-1:0] vcnt;
      scaler_pkg::win_state_t st;
      logic [DW-1:0] last_y;
      logic [DW-1:0] last_c;
      logic [1:0][EW-1:0] fifo;
      logic [1:0] cnt;
      logic ovalid;
      logic ready;
   } state_t;

   state_t s_q, s_d;

   // Returns {hit, set, index} for a subaddress.
   function automatic logic [4:0] decode(input logic [7:0] a);
      if (a >= scaler_pkg::HOUT_LEN_LOW_A_OFS && a <= scaler_pkg::PREFILTER_GAIN_A_OFS) begin
         return {2'b10, 3'(a - scaler_pkg::HOUT_LEN_LOW_A_OFS)};
      end else if (a >= scaler_pkg::HOUT_LEN_LOW_B_OFS && a <= scaler_pkg::PREFILTER_GAIN_B_OFS) begin
         return {2'b11, 3'(a - scaler_pkg::HOUT_LEN_LOW_B_OFS)};
      end else begin
         return 5'h00;
      end
   endfunction

   function automatic logic [7:0] reg_mask(input logic [2:0] idx);
      if (idx == scaler_pkg::IDX_HHI || idx == scaler_pkg::IDX_VHI) begin
         return scaler_pkg::MASK_NIBBLE;
      end else if (idx == scaler_pkg::IDX_RATIO || idx == scaler_pkg::IDX_ACL) begin
         return scaler_pkg::MASK_SIX;
      end else begin
         return scaler_pkg::MASK_BYTE;
      end
   endfunction

   function automatic logic signed [15:0] sx(input logic [DW-1:0] v);
      return $signed(16'(v));
   endfunction

   function automatic logic [DW-1:0] clamp(input logic signed [15:0] v);
      if (v < 16'sh0000) begin
         return '0;
      end else if (v > sx('1)) begin
         return '1;
      end else begin
         return v[DW-1:0];
      end
   endfunction

   // Kernel at x[0] newest; the wide kernel is scaled by four to stay in integers.
   function automatic logic [DW-1:0] luma_filt(input logic [1:0] sel,
                                                input logic [6:0][DW-1:0] x);
      logic signed [15:0] v;
      v = sx(x[0]);
      case (sel)
         scaler_pkg::FILT_QUARTER: v = (sx(x[0]) + 16'sd2 * sx(x[1]) + sx(x[2])) >>> 2;
         scaler_pkg::FILT_WIDE: v = (16'sd4 * (sx(x[1]) + sx(x[5]) - sx(x[0]) - sx(x[6]))
                                   + 16'sd7 * (sx(x[2]) + sx(x[4]))
                                   + 16'sd18 * sx(x[3])) >>> 5;
         scaler_pkg::FILT_FLAT: v = (sx(x[0]) + 16'sd2 * (sx(x[1]) + sx(x[2]) + sx(x[3]))
                                   + sx(x[4])) >>> 3;
         default: v = sx(x[0]);
      endcase
      return clamp(v);
   endfunction

   // Taps are two samples apart so that each one sees the same colour component.
   function automatic logic [DW-1:0] chroma_filt(input logic [1:0] sel,
                                                  input logic [4:0][DW-1:0] x);
      logic signed [15:0] v;
      v = sx(x[0]);
      case (sel)
         scaler_pkg::FILT_QUARTER: v = (sx(x[0]) + 16'sd2 * sx(x[1]) + sx(x[2])) >>> 2;
         scaler_pkg::FILT_WIDE: v = (16'sd3 * (sx(x[0]) + sx(x[4]))
                                   + 16'sd8 * (sx(x[1]) + sx(x[3]))
                                   + 16'sd10 * sx(x[2])) >>> 5;
         scaler_pkg::FILT_FLAT: v = (sx(x[0]) + 16'sd2 * (sx(x[1]) + sx(x[2]) + sx(x[3]))
                                   + sx(x[4])) >>> 3;
         default: v = sx(x[0]);
      endcase
      return clamp(v);
   endfunction

   function automatic logic [DW-1:0] renorm(input logic [AW-1:0] sum, input logic [2:0] k);
      logic [AW-1:0] v;
      v = sum >> k;
      return (v > AW'({DW{1'b1}})) ? '1 : v[DW-1:0];
   endfunction

   logic [4:0] dec;
   logic [7:0] pfg;
   logic [LW-1:0] hlen, vlen;
   logic [LW:0] htarget;
   logic [5:0] ratio, acl;
   logic [2:0] gain;
   logic inner, accept, pop, push, emit, active, in_acc;
   logic [1:0] weight;
   logic [DW-1:0] fy, fc, sy, sc;
   logic [AW-1:0] tot_y;
   logic [1:0][AW-1:0] tot_c;
   logic [EW-1:0] pword;
   logic [LW-1:0] vnow;

   always_comb begin
      s_d = s_q;
      dec = decode(reg_addr_i);
      pfg = s_q.regs[set_sel_i][scaler_pkg::IDX_PFG];
      hlen = {s_q.regs[set_sel_i][scaler_pkg::IDX_HHI][3:0],
              s_q.regs[set_sel_i][scaler_pkg::IDX_HLO]};
      vlen = {s_q.regs[set_sel_i][scaler_pkg::IDX_VHI][3:0],
              s_q.regs[set_sel_i][scaler_pkg::IDX_VLO]};
      // A forbidden zero ratio is treated as one.
      ratio = s_q.regs[set_sel_i][scaler_pkg::IDX_RATIO][5:0];
      ratio = (ratio == 6'h00) ? 6'h01 : ratio;
      acl = s_q.regs[set_sel_i][scaler_pkg::IDX_ACL][5:0];
      gain = pfg[scaler_pkg::GAIN_LSB +: 3];
      inner = pfg[scaler_pkg::WEIGHT_BIT];
      htarget = {1'b0, hlen} + {{LW{1'b0}}, hlen[0]};

      // Register port.
      if (reg_we_i && dec[4]) begin
         s_d.regs[dec[3]][dec[2:0]] = reg_wdata_i & reg_mask(dec[2:0]);
      end
      if (reg_re_i) begin
         s_d.rdata = dec[4] ? s_q.regs[dec[3]][dec[2:0]] : 8'h00;
      end

      accept = in_valid_i && s_q.ready && s_q.st == scaler_pkg::ST_RUN;
      pop = s_q.ovalid && out_ready_i;
      // A start of field restarts the line count before this sample is judged.
      vnow = (accept && in_sof_i) ? '0 : s_q.vcnt;
      active = vnow < vlen;

      // Prefilters, causal.
      fy = luma_filt(pfg[scaler_pkg::LUMA_SEL_LSB +: 2], {s_q.hy, in_y_i});
      fc = chroma_filt(pfg[scaler_pkg::CHROMA_SEL_LSB +: 2],
                       {s_q.hc[7], s_q.hc[5], s_q.hc[3], s_q.hc[1], in_c_i});

      // Accumulation over a ratio period; only the first acl+1 samples count.
      in_acc = s_q.phase <= acl;
      weight = !in_acc ? 2'h0 :
               (inner && s_q.phase != 6'h00 && s_q.phase < acl) ? 2'h2 : 2'h1;
      tot_y = s_q.acc_y + AW'(fy) * AW'(weight);
      tot_c = s_q.acc_c;
      tot_c[s_q.cpar] = s_q.acc_c[s_q.cpar] + AW'(fc) * AW'(weight);
      emit = accept && s_q.phase == ratio - 6'h01;
      sy = renorm(tot_y, gain);
      sc = renorm(tot_c[s_q.hcnt[0]], gain);

      push = 1'b0;
      pword = '0;
      if (accept) begin
         s_d.hy = {s_q.hy[4:0], in_y_i};
         s_d.hc = {s_q.hc[6:0], in_c_i};
         s_d.vcnt = vnow;
         s_d.cpar = ~s_q.cpar;
         if (emit) begin
            s_d.phase = 6'h00;
            s_d.acc_y = '0;
            s_d.acc_c = '0;
            s_d.last_y = sy;
            s_d.last_c = sc;
         end else begin
            s_d.phase = s_q.phase + 6'h01;
            s_d.acc_y = tot_y;
            s_d.acc_c = tot_c;
         end
         if (emit && active && s_q.hcnt < htarget) begin
            push = 1'b1;
            pword = {s_q.hcnt + 13'h0001 == htarget, sy, sc};
            s_d.hcnt = s_q.hcnt + 13'h0001;
         end
         // An incomplete tail is dropped so that every line starts on phase zero.
         if (in_eol_i) begin
            s_d.phase = 6'h00;
            s_d.cpar = 1'b0;
            s_d.acc_y = '0;
            s_d.acc_c = '0;
            if (active && s_d.hcnt < htarget) begin
               s_d.st = scaler_pkg::ST_PAD;
            end else begin
               s_d.hcnt = '0;
               s_d.vcnt = active ? vnow + 12'h001 : vnow;
            end
         end
      // Padding fills free buffer slots while the input side is held off.
      end else if (s_q.st == scaler_pkg::ST_PAD && (s_q.cnt != 2'h2 || pop)) begin
         push = 1'b1;
         pword = {s_q.hcnt + 13'h0001 == htarget, s_q.last_y, s_q.last_c};
         s_d.hcnt = s_q.hcnt + 13'h0001;
         if (s_q.hcnt + 13'h0001 == htarget) begin
            s_d.st = scaler_pkg::ST_RUN;
            s_d.hcnt = '0;
            s_d.vcnt = s_q.vcnt + 12'h001;
         end
      end

      // Two-entry buffer; head entry drives the outputs directly.
      if (pop) begin
         s_d.fifo[0] = s_q.fifo[1];
      end
      if (push) begin
         s_d.fifo[s_q.cnt - 2'(pop)] = pword;
      end
      s_d.cnt = s_q.cnt + 2'(push) - 2'(pop);
      s_d.ovalid = s_d.cnt != 2'h0;
      // One push per cycle at most, so a free slot now covers the next cycle.
      s_d.ready = s_d.cnt != 2'h2 && s_d.st == scaler_pkg::ST_RUN;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         for (int i = 0; i < 2; i++) begin
            s_q.regs[i][scaler_pkg::IDX_RATIO] <= scaler_pkg::RATIO_RST;
            s_q.regs[i][scaler_pkg::IDX_ACL] <= scaler_pkg::OTHER_RST;
         end
         s_q.st <= scaler_pkg::ST_RUN;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign in_ready_o = s_q.ready;
   assign out_valid_o = s_q.ovalid;
   assign {out_eol_o, out_y_o, out_c_o} = s_q.fifo[0];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   zero_length_a: assert property (push |-> htarget != '0)
      else $error("pixel pushed with zero horizontal length");
   even_line_a: assert property (push && pword[EW-1] |-> s_q.hcnt[0])
      else $error("line ended on an odd pixel count");
   pad_repeat_a: assert property (s_q.st == scaler_pkg::ST_PAD && push
                                  |-> pword[2*DW-1:DW] == s_q.last_y)
      else $error("padding pixel differs from last scaled pixel");
   vert_cut_a: assert property (push && s_q.st == scaler_pkg::ST_RUN |-> vnow < vlen)
      else $error("line output beyond vertical length");
   ratio_emit_a: assert property (emit |-> s_q.phase == ratio - 6'h01 && ratio != 6'h00)
      else $error("prescaler emitted off its period");
   accum_span_a: assert property (accept && s_q.phase > acl |-> weight == 2'h0)
      else $error("sample beyond accumulation length was summed");
   flat_weight_a: assert property (accept && !inner && s_q.phase <= acl |-> weight == 2'h1)
      else $error("unit weighting not applied");
   edge_weight_a: assert property (accept && s_q.phase == 6'h00 |-> weight == 2'h1)
      else $error("first sample of a sequence was doubled");
   luma_bypass_a: assert property (pfg[5:4] == 2'h0 && accept |-> fy == in_y_i)
      else $error("luma bypass altered the sample");
   full_stall_a: assert property (s_q.cnt == 2'h2 |-> !in_ready_o ##1 (s_q.cnt != 2'h0))
      else $error("input ready while buffer full");

   // Prefilter, gain, weighting, ratio and accumulation phase.
   chroma_bypass_a: assert property (pfg[7:6] == 2'h0 && accept
                                     |-> fc == in_c_i)
      else $error("chroma bypass altered the sample");
   gain_shift_a: assert property (emit && (tot_y >> gain) <= AW'({DW{1'b1}})
                                  |-> AW'(sy) == (tot_y >> gain))
      else $error("renormalized sum is not the shifted sum");
   inner_double_a: assert property (accept && inner && s_q.phase != 6'h00
                                    && s_q.phase < acl |-> weight == 2'h2)
      else $error("interior sample was not doubled");
   last_weight_a: assert property (accept && s_q.phase == acl
                                   && s_q.phase != 6'h00 |-> weight == 2'h1)
      else $error("last sample of a sequence was doubled");
   ratio_zero_a: assert property (s_q.regs[set_sel_i][scaler_pkg::IDX_RATIO][5:0] == 6'h00
                                  |-> ratio == 6'h01)
      else $error("forbidden zero ratio was used as is");
   tail_drop_a: assert property (accept && in_eol_i
                                 |=> s_q.phase == 6'h00)
      else $error("accumulation phase carried across a line end");

   // Window lengths and line counting.
   vert_zero_a: assert property (vlen == '0
                                 |-> !active)
      else $error("zero vertical length left the window open");
   inactive_quiet_a: assert property (accept && !active
                                      |-> !push)
      else $error("pixel pushed outside the vertical window");
   line_count_a: assert property (s_q.st == scaler_pkg::ST_PAD && push && pword[EW-1]
                                  |=> s_q.vcnt == $past(s_q.vcnt) + LW'(1))
      else $error("padded line did not advance the line count");
   field_restart_a: assert property (accept && in_sof_i
                                     |=> s_q.vcnt <= LW'(1))
      else $error("start of field did not restart the line count");
   pad_end_a: assert property (s_q.st == scaler_pkg::ST_PAD && push && pword[EW-1]
                               |=> s_q.st == scaler_pkg::ST_RUN)
      else $error("padding went on past the line end");
   pad_stall_a: assert property (s_q.st == scaler_pkg::ST_PAD
                                 |-> !in_ready_o)
      else $error("input ready while padding");
   odd_round_a: assert property (hlen[0]
                                 |-> htarget == {1'b0, hlen} + (LW+1)'(1))
      else $error("odd horizontal length not rounded up");

   // Register port and output buffer.
   reg_write_a: assert property (reg_we_i && dec[4]
                                 |=> s_q.regs[$past(dec[3])][$past(dec[2:0])]
                                     == ($past(reg_wdata_i) & reg_mask($past(dec[2:0]))))
      else $error("register write did not land in its set");
   unmapped_read_a: assert property (reg_re_i && !dec[4]
                                     |=> reg_rdata_o == 8'h00)
      else $error("unmapped subaddress read as nonzero");
   rdata_hold_a: assert property (!reg_re_i
                                  |=> $stable(reg_rdata_o))
      else $error("read data changed without a read");
   out_hold_a: assert property (out_valid_o && !out_ready_i
                                |=> out_valid_o && $stable({out_eol_o, out_y_o, out_c_o}))
      else $error("output word changed while stalled");

   pad_seen_c: cover property (s_q.st == scaler_pkg::ST_RUN ##1 s_q.st == scaler_pkg::ST_PAD);
   buf_full_c: cover property (s_q.cnt == 2'h2 && !out_ready_i);
   line_done_c: cover property (push && pword[EW-1]);
   odd_len_c: cover property (push && pword[EW-1] && hlen[0]);
   double_c: cover property (accept && weight == 2'h2);
endmodule // scaler_prescale_output_window

/* hw/scaler_pkg.sv */
// Register map, field layout, reset values and enumerations of the prescaler and output window.
package scaler_pkg;
   // Subaddresses of parameter set A and parameter set B.
   localparam logic [7:0] HOUT_LEN_LOW_A_OFS = 8'h9C;
   localparam logic [7:0] HOUT_LEN_HIGH_A_OFS = 8'h9D;
   localparam logic [7:0] VOUT_LEN_LOW_A_OFS = 8'h9E;
   localparam logic [7:0] VOUT_LEN_HIGH_A_OFS = 8'h9F;
   localparam logic [7:0] PRESCALE_RATIO_A_OFS = 8'hA0;
   localparam logic [7:0] ACCUM_LENGTH_A_OFS = 8'hA1;
   localparam logic [7:0] PREFILTER_GAIN_A_OFS = 8'hA2;
   localparam logic [7:0] HOUT_LEN_LOW_B_OFS = 8'hCC;
   localparam logic [7:0] HOUT_LEN_HIGH_B_OFS = 8'hCD;
   localparam logic [7:0] VOUT_LEN_LOW_B_OFS = 8'hCE;
   localparam logic [7:0] VOUT_LEN_HIGH_B_OFS = 8'hCF;
   localparam logic [7:0] PRESCALE_RATIO_B_OFS = 8'hD0;
   localparam logic [7:0] ACCUM_LENGTH_B_OFS = 8'hD1;
   localparam logic [7:0] PREFILTER_GAIN_B_OFS = 8'hD2;

   // Register index inside one set.
   localparam int REG_CNT = 7;
   localparam logic [2:0] IDX_HLO = 3'h0;
   localparam logic [2:0] IDX_HHI = 3'h1;
   localparam logic [2:0] IDX_VLO = 3'h2;
   localparam logic [2:0] IDX_VHI = 3'h3;
   localparam logic [2:0] IDX_RATIO = 3'h4;
   localparam logic [2:0] IDX_ACL = 3'h5;
   localparam logic [2:0] IDX_PFG = 3'h6;

   // Implemented bits per register; the rest read as zero.
   localparam logic [7:0] MASK_BYTE = 8'hFF;
   localparam logic [7:0] MASK_NIBBLE = 8'h0F;
   localparam logic [7:0] MASK_SIX = 8'h3F;

   // Values after reset.
   localparam logic [7:0] RATIO_RST = 8'h01;
   localparam logic [7:0] OTHER_RST = 8'h00;

   // Fields of the prefilter and gain register.
   localparam int GAIN_LSB = 0;
   localparam int WEIGHT_BIT = 3;
   localparam int LUMA_SEL_LSB = 4;
   localparam int CHROMA_SEL_LSB = 6;

   localparam int FIFO_DEPTH = 2;

   typedef enum logic [1:0] {
      FILT_BYPASS = 2'h0,
      FILT_QUARTER = 2'h1,
      FILT_WIDE = 2'h2,
      FILT_FLAT = 2'h3
   } filt_t;

   typedef enum logic {
      ST_RUN = 1'h0,
      ST_PAD = 1'h1
   } win_state_t;
endpackage

/* testbench/video_source.sv */
// Upstream sample source that feeds queued luma samples to the prescaler.
module video_source (
   // Clock
   input wire logic clk_i,
   // Sample stream
   input wire logic ready_i,
   output logic valid_o,
   output logic [7:0] y_o,
   output logic [7:0] c_o,
   output logic eol_o,
   output logic sof_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] fifo_q[$];
   logic [9:0] w;
   logic taken = 1'b0;
   initial begin
      valid_o = 1'b0;
      y_o = 8'h00;
      c_o = 8'h00;
      eol_o = 1'b0;
      sof_o = 1'b0;
   end
   always @(posedge clk_i) taken <= valid_o && ready_i;
   // An idle source shows inverted data, so a stale sample never passes for a new one.
   always @(negedge clk_i) begin
      if (!valid_o || taken) begin
         if (fifo_q.size() > 0) begin
            w = fifo_q.pop_front();
            valid_o <= 1'b1;
            y_o <= w[7:0];
            c_o <= 8'h80;
            eol_o <= w[8];
            sof_o <= w[9];
         end else begin
            valid_o <= 1'b0;
            y_o <= ~y_o;
            c_o <= ~c_o;
            eol_o <= 1'b0;
            sof_o <= 1'b0;
         end
      end
   end
endmodule // video_source

/* testbench/tb_scaler_prescale_output_window.sv */
// Self-checking bench of the prescaler and output window block.
module tb_scaler_prescale_output_window;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, reg_we, reg_re, set_sel;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, in_y, in_c, out_y, out_c;
   logic in_valid, in_ready, in_eol, in_sof, out_valid, out_ready, out_eol;
   logic [16:0] got_q[$];
   int fail_count, total_checks, cycles;

   scaler_prescale_output_window dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
      .reg_rdata_o(reg_rdata), .set_sel_i(set_sel), .in_valid_i(in_valid),
      .in_ready_o(in_ready), .in_y_i(in_y), .in_c_i(in_c), .in_eol_i(in_eol),
      .in_sof_i(in_sof), .out_valid_o(out_valid), .out_ready_i(out_ready),
      .out_y_o(out_y), .out_c_o(out_c), .out_eol_o(out_eol));
   video_source src (.clk_i(clk_i), .ready_i(in_ready), .valid_o(in_valid), .y_o(in_y),
      .c_o(in_c), .eol_o(in_eol), .sof_o(in_sof));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (out_valid && out_ready) got_q.push_back({out_eol, out_c, out_y});
   end
   // The ceiling is about fifty times the length of the whole sequence.
   always @(negedge clk_i) if (cycles == 20000) begin
      fail_count++;
      print_verdict();
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_word(input logic [8:0] got, input logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_we = 1'b1;
      @(negedge clk_i);
      reg_we = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_re = 1'b1;
      @(negedge clk_i);
      reg_re = 1'b0;
      @(negedge clk_i);
      check_reg(reg_rdata, exp);
   endtask
   task automatic setup(input logic s, input logic [11:0] h, input logic [11:0] v,
                        input logic [7:0] r, input logic [7:0] a, input logic [7:0] p);
      logic [7:0] b;
      b = s ? scaler_pkg::HOUT_LEN_LOW_B_OFS : scaler_pkg::HOUT_LEN_LOW_A_OFS;
      reg_wr(b, h[7:0]);
      reg_wr(b + 8'h01, {4'h0, h[11:8]});
      reg_wr(b + 8'h02, v[7:0]);
      reg_wr(b + 8'h03, {4'h0, v[11:8]});
      reg_wr(b + 8'h04, r);
      reg_wr(b + 8'h05, a);
      reg_wr(b + 8'h06, p);
      set_sel = s;
   endtask
   task automatic send_line(input int n, input logic [7:0] y0, input logic [7:0] dy,
                            input logic f);
      for (int i = 0; i < n; i++)
         src.fifo_q.push_back({f && i == 0, i == n - 1, 8'(y0 + dy * i)});
   endtask
   task automatic expect_out(input int n, input logic [3:0][8:0] e);
      for (int i = 0; i < 300 && got_q.size() < n; i++) @(negedge clk_i);
      repeat (20) @(negedge clk_i);
      check_word(9'(got_q.size()), 9'(n));
      for (int i = 0; i < n && i < got_q.size(); i++)
         check_word({got_q[i][16], got_q[i][7:0]}, e[i]);
      got_q.delete();
   endtask

   task automatic t_regs();
      reg_rd(scaler_pkg::PRESCALE_RATIO_A_OFS, 8'h01);
      reg_rd(scaler_pkg::PRESCALE_RATIO_B_OFS, 8'h01);
      reg_rd(scaler_pkg::HOUT_LEN_LOW_A_OFS, 8'h00);
      reg_wr(scaler_pkg::HOUT_LEN_HIGH_B_OFS, 8'hFF);
      reg_rd(scaler_pkg::HOUT_LEN_HIGH_B_OFS, 8'h0F);
      reg_wr(scaler_pkg::ACCUM_LENGTH_A_OFS, 8'hFF);
      reg_rd(scaler_pkg::ACCUM_LENGTH_A_OFS, 8'h3F);
      reg_rd(scaler_pkg::ACCUM_LENGTH_B_OFS, 8'h00);
      reg_wr(8'hA3, 8'h5A);
      reg_rd(8'hA3, 8'h00);
      $display("test registers done");
   endtask
   task automatic t_sum();
      setup(1'b0, 12'h002, 12'h001, 8'h02, 8'h01, 8'h01);
      send_line(4, 8'h10, 8'h10, 1'b1);
      expect_out(2, {9'h000, 9'h000, 9'h138, 9'h018});
      setup(1'b1, 12'h002, 12'h001, 8'h03, 8'h02, 8'h0A);
      send_line(6, 8'h10, 8'h10, 1'b1);
      expect_out(2, {9'h000, 9'h000, 9'h150, 9'h020});
      $display("test accumulation done");
   endtask
   task automatic t_pad();
      setup(1'b0, 12'h003, 12'h001, 8'h01, 8'h00, 8'h00);
      out_ready = 1'b0;
      send_line(2, 8'h11, 8'h11, 1'b1);
      repeat (12) @(negedge clk_i);
      check_word({8'h00, in_ready}, 9'h000);
      out_ready = 1'b1;
      expect_out(4, {9'h122, 9'h022, 9'h022, 9'h011});
      $display("test padding done");
   endtask
   task automatic t_vert();
      setup(1'b0, 12'h002, 12'h001, 8'h01, 8'h00, 8'h00);
      send_line(2, 8'h05, 8'h01, 1'b1);
      send_line(2, 8'hA0, 8'h01, 1'b0);
      expect_out(2, {9'h000, 9'h000, 9'h106, 9'h005});
      for (int k = 0; k < 2; k++) begin
         setup(1'b0, k ? 12'h002 : 12'h000, k ? 12'h000 : 12'h001, 8'h01, 8'h00, 8'h00);
         send_line(2, 8'h30, 8'h01, 1'b1);
         expect_out(0, '0);
      end
      $display("test vertical done");
   endtask
   // Flat input shows the DC gain of each kernel once the history is filled.
   task automatic t_filt();
      for (int k = 0; k < 4; k++) begin
         setup(1'b0, 12'h008, 12'h001, 8'h01, 8'h00, {2'(k), 2'(k), 4'h0});
         send_line(8, 8'h40, 8'h00, 1'b1);
         for (int i = 0; i < 300 && got_q.size() < 8; i++) @(negedge clk_i);
         check_word({got_q[7][16], got_q[7][7:0]}, 9'h140);
         check_reg(got_q[7][15:8], 8'h80);
         got_q.delete();
      end
      $display("test prefilters done");
   endtask

   initial begin
      rst_i = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_we = 1'b0;
      reg_re = 1'b0;
      set_sel = 1'b0;
      out_ready = 1'b1;
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      t_regs();
      t_sum();
      t_pad();
      t_vert();
      t_filt();
      print_verdict();
   end
endmodule // tb_scaler_prescale_output_window
